// ---- shared/bus_master_regs.svh ----
/*
 * Constants for the backplane bus service master: level codes, pin
 * widths and the timing counts of the service cycle.
 * Assumes a 40 MHz system clock.
 */
// Notes on behaviour
// RULE_01: A granted processor stays off the request line until it idles.
// RULE_02: Fixed priority settles requests on different request lines.
// RULE_03: The processor request line has the lowest priority of all lines.
// RULE_04: Of equal-level requesters, the one nearest the controller wins.
// RULE_05: A module not requesting on the selected level passes the pulse on.
// RULE_06: On select and pulse, acknowledge first, then drop the request.
// RULE_07: A device select cycle starts only once acknowledge is withdrawn.
// RULE_08: Interrupt select cycles also wait until acknowledge is gone.
// RULE_09: The request line returns high after acknowledge has gone low.
// RULE_10: The matching select is asserted and dropped on acknowledge.
// RULE_11: Processor select and pulse grant the nearest requesting processor.
// RULE_12: Strobe comes only once address, control and write data are stable.
// RULE_13: Strobe removal ends a cycle and lets the waiting master start.
// RULE_14: Done ends a cycle: valid read data, or write data accepted.
// RULE_15: On done the master withdraws address, control and data.
// RULE_16: Quit is raised when done is missing 5 us after cycle start.
// RULE_17: Quit may also come from parity, coupler or protection faults.
// RULE_18: On quit the master ends its cycle; the transfer is invalid.
// RULE_19: The pulse follows the select line after a delay.
// RULE_20: A held acknowledge blocks further select cycles.
// RULE_21: One select cycle at a time, with one pulse per cycle.
// RULE_22: Request, select, acknowledge, strobe, done and quit are active low.
`ifndef BUS_MASTER_REGS_SVH
`define BUS_MASTER_REGS_SVH

`define LEVEL_DEVICE 0
`define LEVEL_INT1 1
`define LEVEL_INT4 4
`define LEVEL_PROC 5
`define LEVEL_COUNT 6
`define ADDR_W 16
`define DATA_W 16

`define CLK_PERIOD_NS 25
`define SETUP_NS 50
`define SETUP_CYC ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TICK_W 4

`endif

// ---- shared/bus_master_pkg.sv ----
/*
 * Types of the backplane bus service master: state encoding and the
 * structs that carry bus pins and user requests.
 * Assumes the constants header is on the include path.
 */
`include "bus_master_regs.svh"

package bus_master_pkg;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_REQ = 7'h02,
        ST_ACK = 7'h04,
        ST_WAIT = 7'h08,
        ST_SETUP = 7'h10,
        ST_STROBE = 7'h20,
        ST_END = 7'h40
    } state_e;

    typedef struct packed {
        logic [`LEVEL_COUNT-1:0] select_n;
        logic processorRequest_n;
        logic precedenceIn;
        logic selectAck_n;
        logic cycleStrobe_n;
        logic done_n;
        logic quit_n;
        logic [`DATA_W-1:0] data;
    } busIn_s;

    typedef struct packed {
        logic [`LEVEL_COUNT-1:0] requestOe;
        logic [`LEVEL_COUNT-1:0] request_n;
        logic selectAckOe;
        logic selectAck_n;
        logic strobeOe;
        logic cycleStrobe_n;
        logic precedenceOut;
        logic driveOe;
        logic write_n;
        logic [`ADDR_W-1:0] addr_n;
        logic [`DATA_W-1:0] data_n;
    } busOut_s;

    typedef struct packed {
        logic write;
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] data;
    } cmd_s;

    typedef struct packed {
        logic valid;
        logic abort;
        logic [`DATA_W-1:0] data;
    } rsp_s;

    typedef struct packed {
        state_e state;
        logic lockout;
        cmd_s cmd;
        rsp_s rsp;
    } master_s;

endpackage : bus_master_pkg

// ---- rtl/tick_counter.sv ----
/*
 * Down counter that times a fixed number of clock enables.
 * Assumes load and tick come from the same clock domain.
 */
`timescale 1ns/1ps
module tick_counter #(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic load,
    input wire logic [W-1:0] loadVal,
    input wire logic tick,
    output logic expired
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (load) begin
            cnt_nxt = loadVal;
        end else if (tick && cnt_r != '0) begin
            cnt_nxt = cnt_r - W'(1);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign expired = (cnt_r == '0) && !load;
endmodule : tick_counter

// ---- rtl/precedence_cell.sv ----
/*
 * One link of the precedence chain: passes or traps the pulse.
 * Assumes the pulse is active high and select is active low.
 */
`timescale 1ns/1ps
module precedence_cell (
    input wire logic precIn,
    input wire logic selectMine_n,
    input wire logic pending,
    output logic precOut,
    output logic capture
);
    logic trapping;

    // The pulse is held only while the own level is selected and pending.
    assign trapping = pending && !selectMine_n; // RULE_04
    assign capture = trapping && precIn; // RULE_11
    assign precOut = trapping ? 1'b0 : precIn; // RULE_05
endmodule : precedence_cell

// ---- rtl/bus_service_master.sv ----
/*
 * Master module on the shared backplane bus: requests the bus on one
 * level, takes part in the precedence chain, acknowledges selection and
 * runs one strobe-timed service cycle per user command.
 * Assumes a bus controller and slaves outside; pins are open drain and
 * resolved outside; all pin inputs are synchronous to clk.
 */
`timescale 1ns/1ps
`include "bus_master_regs.svh"
module bus_service_master #(
    parameter int LEVEL = `LEVEL_DEVICE,
    parameter int SETUP_CYC = `SETUP_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire bus_master_pkg::cmd_s cmd,
    input wire logic cmdValid,
    output logic cmdReady,
    output bus_master_pkg::rsp_s rsp,
    input wire bus_master_pkg::busIn_s busIn,
    output bus_master_pkg::busOut_s busOut
);
    localparam logic [`TICK_W-1:0] SETUP_LOAD = `TICK_W'(SETUP_CYC - 1);
    localparam bit IS_PROC = (LEVEL == `LEVEL_PROC);

    bus_master_pkg::master_s st_r;
    bus_master_pkg::master_s st_nxt;
    logic capture;
    logic precOut;
    logic pending;
    logic setupLoad;
    logic setupDone;
    logic reqOe;
    logic ackOe;
    logic strobeOe;
    logic driveOe;

    // The request stays pending while its line is still pulled low, so a
    // pulse that lingers into the acknowledge cycle is trapped as well.
    assign pending = reqOe; // RULE_05

    precedence_cell u_prec (
        .precIn(busIn.precedenceIn),
        .selectMine_n(busIn.select_n[LEVEL]),
        .pending(pending),
        .precOut(precOut),
        .capture(capture)
    );

    assign setupLoad = (st_r.state == bus_master_pkg::ST_WAIT);

    tick_counter #(
        .W(`TICK_W)
    ) u_setup (
        .clk(clk),
        .arst_n(arst_n),
        .load(setupLoad),
        .loadVal(SETUP_LOAD),
        .tick(1'b1),
        .expired(setupDone)
    );

    // A processor stays locked out until the shared line has gone idle.
    assign cmdReady = (st_r.state == bus_master_pkg::ST_IDLE)
        && !(IS_PROC && st_r.lockout); // RULE_01

    always_comb begin
        st_nxt = st_r;
        st_nxt.rsp.valid = 1'b0;
        // The lock clears once no one else drives the processor line.
        if (st_r.state == bus_master_pkg::ST_IDLE
            && busIn.processorRequest_n) begin
            st_nxt.lockout = 1'b0; // RULE_01
        end
        case (st_r.state)
            bus_master_pkg::ST_IDLE: begin
                if (cmdValid && cmdReady) begin
                    st_nxt.cmd = cmd;
                    st_nxt.state = bus_master_pkg::ST_REQ;
                end
            end
            bus_master_pkg::ST_REQ: begin
                if (capture) begin
                    st_nxt.state = bus_master_pkg::ST_ACK; // RULE_06
                    st_nxt.lockout = IS_PROC; // RULE_01
                end
            end
            bus_master_pkg::ST_ACK: begin
                st_nxt.state = bus_master_pkg::ST_WAIT; // RULE_09
            end
            bus_master_pkg::ST_WAIT: begin
                // Acknowledge is held until the bus is free, which keeps
                // the controller from starting another select cycle.
                if (busIn.cycleStrobe_n) begin
                    st_nxt.state = bus_master_pkg::ST_SETUP; // RULE_13
                end
            end
            bus_master_pkg::ST_SETUP: begin
                if (setupDone) begin
                    st_nxt.state = bus_master_pkg::ST_STROBE; // RULE_12
                end
            end
            bus_master_pkg::ST_STROBE: begin
                // Quit wins over done: a faulted transfer always reports valid with abort set.
                if (!busIn.quit_n) begin
                    st_nxt.rsp.valid = 1'b1; // RULE_18
                    st_nxt.rsp.abort = 1'b1; // RULE_17
                    st_nxt.state = bus_master_pkg::ST_END;
                end else if (!busIn.done_n) begin
                    st_nxt.rsp.valid = 1'b1;
                    st_nxt.rsp.abort = 1'b0;
                    if (!st_r.cmd.write) begin
                        st_nxt.rsp.data = ~busIn.data; // RULE_14
                    end
                    st_nxt.state = bus_master_pkg::ST_END; // RULE_15
                end
            end
            bus_master_pkg::ST_END: begin
                // Waiting for done and quit to clear avoids taking a
                // stale answer into the next cycle.
                if (busIn.done_n && busIn.quit_n) begin
                    st_nxt.state = bus_master_pkg::ST_IDLE;
                end
            end
            default: begin
                st_nxt.state = bus_master_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '{state: bus_master_pkg::ST_IDLE, lockout: 1'b0,
                cmd: '0, rsp: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reqOe = (st_r.state == bus_master_pkg::ST_REQ)
        || (st_r.state == bus_master_pkg::ST_ACK); // RULE_06
    assign ackOe = (st_r.state == bus_master_pkg::ST_ACK)
        || (st_r.state == bus_master_pkg::ST_WAIT); // RULE_20
    assign strobeOe = (st_r.state == bus_master_pkg::ST_STROBE);
    assign driveOe = (st_r.state == bus_master_pkg::ST_SETUP)
        || strobeOe; // RULE_15

    always_comb begin
        busOut = '0;
        busOut.requestOe[LEVEL] = reqOe;
        // Open-drain lines only ever pull low when enabled.
        busOut.request_n = '0; // RULE_22
        busOut.selectAckOe = ackOe;
        busOut.selectAck_n = 1'b0;
        busOut.strobeOe = strobeOe;
        busOut.cycleStrobe_n = 1'b0;
        busOut.precedenceOut = precOut;
        busOut.driveOe = driveOe;
        busOut.write_n = ~st_r.cmd.write;
        busOut.addr_n = ~st_r.cmd.addr;
        busOut.data_n = st_r.cmd.write ? ~st_r.cmd.data : '1;
    end

    assign rsp = st_r.rsp;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    a_ack_then_release: assert property ( // RULE_06
        $fell(reqOe) |-> ackOe && $past(ackOe))
        else $error("request released without acknowledge");
    a_release_after_ack: assert property ( // RULE_09
        $rose(ackOe) |=> !reqOe)
        else $error("request still held after acknowledge");
    a_chain_trap: assert property ( // RULE_04
        capture |-> !busOut.precedenceOut ##1 ackOe)
        else $error("captured pulse leaked or not acknowledged");
    a_trap_hold: assert property ( // RULE_04
        (reqOe && !busIn.select_n[LEVEL]) |-> !busOut.precedenceOut)
        else $error("pulse passed while own request pending");
    a_chain_pass: assert property ( // RULE_05
        !pending |-> busOut.precedenceOut == busIn.precedenceIn)
        else $error("idle module blocked the precedence pulse");
    a_proc_lockout: assert property ( // RULE_01
        (IS_PROC && st_r.lockout && st_r.state == bus_master_pkg::ST_IDLE)
            |-> !cmdReady ##1 !reqOe)
        else $error("processor requested again while locked out");
    a_wait_strobe: assert property ( // RULE_13
        $rose(driveOe) |-> $past(busIn.cycleStrobe_n)
            && $past(ackOe))
        else $error("cycle started while bus still strobed");
    a_strobe_setup: assert property ( // RULE_12
        $rose(strobeOe) |-> $past(driveOe) && driveOe)
        else $error("strobe without stable bus contents");
    a_done_release: assert property ( // RULE_15
        (strobeOe && !busIn.done_n && busIn.quit_n)
            |=> !driveOe && !strobeOe && rsp.valid && !rsp.abort)
        else $error("bus not released on done");
    a_quit_abort: assert property ( // RULE_18
        (strobeOe && !busIn.quit_n) |=> rsp.valid && rsp.abort
            && !strobeOe)
        else $error("quit did not abort the cycle");
    a_ack_blocks: assert property ( // RULE_20
        (st_r.state == bus_master_pkg::ST_WAIT && !busIn.cycleStrobe_n)
            |=> ackOe)
        else $error("acknowledge dropped before bus was free");
    a_rsp_single: assert property (
        rsp.valid |=> !rsp.valid)
        else $error("response longer than one cycle");

    c_write_done: cover property (
        strobeOe && st_r.cmd.write && !busIn.done_n ##1 rsp.valid);
    c_read_done: cover property (
        strobeOe && !st_r.cmd.write && !busIn.done_n ##1 rsp.valid);
    c_quit: cover property (strobeOe && !busIn.quit_n);
    c_pass_while_req: cover property (
        pending && busIn.select_n[LEVEL] && busIn.precedenceIn);
endmodule : bus_service_master

// ---- dv/bus_partner_model.sv ----
/*
 * Bus controller, downstream requester and slave for one service master.
 * Assumes every bus line is open drain with a pull-up, so a released
 * line reads high.
 */
`timescale 1ns/1ps
module bus_partner_model #(
    parameter int TMO_CYC = 200
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire bus_master_pkg::busOut_s busOut,
    input wire logic [5:0] otherReq,
    input wire logic [1:0] mode,
    input wire logic [3:0] delay,
    input wire logic [15:0] rdData,
    output bus_master_pkg::busIn_s busIn,
    output logic otherAck,
    output logic [15:0] wrAddr
);
    logic sel;
    logic [2:0] lvl;
    logic [3:0] cnt;
    logic [8:0] sc;
    logic doneR;
    logic quitR;
    logic [5:0] pend;
    logic pulse;
    logic ackN;
    logic [2:0] first;
    assign pend = busOut.requestOe | otherReq;
    // The pulse trails select by two cycles and comes once per cycle.
    assign pulse = sel && (cnt == 4'h2 || cnt == 4'h3);
    assign ackN = !(busOut.selectAckOe || otherAck);
    always_comb begin
        first = 3'h0;
        for (int i = 5; i >= 0; i--) begin
            if (pend[i]) first = 3'(i);
        end
        busIn.select_n = sel ? ~(6'h01 << lvl) : 6'h3f;
        busIn.processorRequest_n = !pend[5];
        busIn.precedenceIn = pulse;
        busIn.selectAck_n = ackN;
        busIn.cycleStrobe_n = !busOut.strobeOe;
        busIn.done_n = !doneR;
        busIn.quit_n = !quitR;
        busIn.data = doneR ? ~rdData : 16'hffff;
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sel <= 1'b0;
            lvl <= 3'h0;
            cnt <= 4'h0;
            otherAck <= 1'b0;
            sc <= 9'h0;
            doneR <= 1'b0;
            quitR <= 1'b0;
            wrAddr <= 16'h0;
        end else begin
            if (!sel && ackN && pend != 6'h0) begin
                sel <= 1'b1;
                lvl <= first;
                cnt <= 4'h0;
            end else if (sel) begin
                cnt <= cnt + 4'h1;
                // An uncaptured pulse must not hang the chain for good.
                if (!ackN || cnt == 4'hf) sel <= 1'b0;
            end
            if (!otherReq[lvl]) otherAck <= 1'b0;
            else if (pulse && busOut.precedenceOut) begin
                otherAck <= 1'b1;
            end
            if (!busOut.strobeOe) begin
                sc <= 9'h0;
                doneR <= 1'b0;
                quitR <= 1'b0;
            end else begin
                sc <= sc + 9'h1;
                if (sc == 9'h0) wrAddr <= ~busOut.addr_n;
                if (sc == {5'h0, delay}) begin
                    doneR <= (mode == 2'h0);
                    quitR <= (mode == 2'h1);
                end
                if (sc == 9'(TMO_CYC) && !doneR) quitR <= 1'b1;
            end
        end
    end
endmodule : bus_partner_model

// ---- dv/bus_service_master_tb.sv ----
/*
 * Self-checking bench of the service master against the partner model.
 * Assumes a 40 MHz clock and the partner's pull-up bus lines.
 */
`timescale 1ns/1ps
module bus_service_master_tb;
    logic clk;
    logic arst_n;
    bus_master_pkg::cmd_s cmd;
    logic cmdValid;
    logic cmdReady;
    bus_master_pkg::rsp_s rsp;
    bus_master_pkg::rsp_s r;
    bus_master_pkg::busIn_s busIn;
    bus_master_pkg::busOut_s busOut;
    logic [5:0] otherReq;
    logic [1:0] mode;
    logic [3:0] delay;
    logic [15:0] rdData;
    logic otherAck;
    logic [15:0] wrAddr;
    int failures = 0;
    int nTests = 0;
    int sc;
    bus_service_master #(.LEVEL(0), .SETUP_CYC(2)) u_bus_service_master (
        .clk(clk), .arst_n(arst_n), .cmd(cmd), .cmdValid(cmdValid),
        .cmdReady(cmdReady), .rsp(rsp), .busIn(busIn), .busOut(busOut));
    bus_partner_model #(.TMO_CYC(200)) u_bus_partner_model (
        .clk(clk), .arst_n(arst_n), .busOut(busOut), .otherReq(otherReq),
        .mode(mode), .delay(delay), .rdData(rdData), .busIn(busIn),
        .otherAck(otherAck), .wrAddr(wrAddr));
    task automatic chk(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
        nTests++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic run_cmd(input logic w, input logic [15:0] a,
                           input logic [15:0] d);
        logic rdy;
        sc = 0;
        cmd <= '{w, a, d};
        cmdValid <= 1'b1;
        do begin
            @(negedge clk);
            rdy = cmdReady;
            @(posedge clk);
        end while (rdy !== 1'b1);
        cmdValid <= 1'b0;
        for (int i = 0; i < 1000 && rsp.valid !== 1'b1; i++) begin
            @(negedge clk);
            if (busOut.strobeOe === 1'b1 && sc == 0) begin
                chk("drive", 16'(busOut.driveOe), 16'h1);
                chk("addr", ~busOut.addr_n, a);
            end
            if (busOut.strobeOe === 1'b1) sc++;
        end
        r = rsp;
        chk("valid", 16'(rsp.valid), 16'h1);
        chk("release", 16'(busOut.driveOe), 16'h0);
        @(posedge clk);
    endtask : run_cmd
    task automatic test_cycles();
        mode <= 2'h0;
        delay <= 4'h3;
        run_cmd(1'b1, 16'h1234, 16'habcd);
        chk("wrAddr", wrAddr, 16'h1234);
        chk("wrAbort", 16'(r.abort), 16'h0);
        rdData <= 16'h5a3c;
        delay <= 4'h0;
        run_cmd(1'b0, 16'h0ff0, 16'h0);
        chk("rdData", r.data, 16'h5a3c);
        mode <= 2'h1;
        run_cmd(1'b1, 16'h0001, 16'h0);
        chk("parity", 16'(r.abort), 16'h1);
        mode <= 2'h2;
        run_cmd(1'b0, 16'h0002, 16'h0);
        chk("timeout", 16'(r.abort), 16'h1);
        chk("tmoSpan", 16'(sc >= 200 && sc <= 205), 16'h1);
        $display("test_cycles finished");
    endtask : test_cycles
    task automatic test_chain();
        otherReq <= 6'h02;
        for (int i = 0; i < 40 && busIn.precedenceIn !== 1'b1; i++)
            @(negedge clk);
        chk("pass", 16'(busOut.precedenceOut), 16'h1);
        for (int i = 0; i < 40 && otherAck !== 1'b1; i++) @(posedge clk);
        otherReq <= 6'h22;
        fork
            run_cmd(1'b1, 16'h0042, 16'h0);
            begin
                repeat (6) @(negedge clk);
                chk("held", 16'(busIn.select_n), 16'h3f);
                @(posedge clk);
                otherReq <= 6'h20;
                for (int i = 0; i < 40 && busIn.select_n === 6'h3f; i++)
                    @(negedge clk);
                chk("prio", 16'(busIn.select_n), 16'h3e);
                for (int i = 0; i < 40 && busIn.precedenceIn !== 1'b1; i++)
                    @(negedge clk);
                chk("trap", 16'(busOut.precedenceOut), 16'h0);
                @(negedge clk);
                chk("trapAck", 16'(busOut.precedenceOut), 16'h0);
            end
        join
        for (int i = 0; i < 40 && otherAck !== 1'b1; i++) @(posedge clk);
        chk("procAck", 16'(otherAck), 16'h1);
        otherReq <= 6'h00;
        repeat (4) @(posedge clk);
        $display("test_chain finished");
    endtask : test_chain
    task automatic test_done();
        $display("compares %0d mismatches %0d", nTests, failures);
        if (failures == 0 && nTests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        // The whole run needs under a thousand cycles.
        repeat (20000) @(posedge clk);
        failures++;
        test_done();
    end
    initial begin
        arst_n = 1'b0;
        cmd = '0;
        cmdValid = 1'b0;
        otherReq = 6'h0;
        mode = 2'h0;
        delay = 4'h0;
        rdData = 16'h0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        chk("ready", 16'(cmdReady), 16'h1);
        chk("idleReq", 16'(busOut.requestOe), 16'h0);
        @(posedge clk);
        test_cycles();
        test_chain();
        test_done();
    end
endmodule : bus_service_master_tb
